// ===== fmu_defs.svh
`ifndef FMU_DEFS_SVH
`define FMU_DEFS_SVH
`define FMU_CTRL 8'h00
`define FMU_STAT 8'h04
`define FMU_TAGW 8'h08
`define FMU_SEL 8'h0c
`define FMU_DLO 8'h10
`define FMU_DMID 8'h14
`define FMU_DHI 8'h18
`define FMU_CTRL_RST 32'h0000_0000
`define FMU_CTRL_MASK 32'h0000_001f
`define FMU_EM_BIT 2
`define FMU_TS_BIT 3
`define FMU_ACEN_BIT 4
`define FMU_TOP_LSB 8
`define FMU_COMMIT_BIT 3
`define FMU_C1_BIT 16
`define FMU_TAG_RST 8'h00
`define FMU_TOP_RST 3'h0
`define FMU_BIAS 18'sh03fff
`define FMU_EMAX 18'sh07fff
`define FMU_EXP_MAX 15'h7fff
`define FMU_SGL_ADJ 15'h3f80
`define FMU_DBL_ADJ 15'h3c00
`define FMU_INT_EXP 15'h401e
`define FMU_INT_BIT 64'h8000_0000_0000_0000
`define FMU_QNAN_IND 80'hffff_c000_0000_0000_0000
`define FMU_OPC_SGL 8'hd8
`define FMU_OPC_DBL 8'hdc
`define FMU_OPC_I32 8'hda
`define FMU_OPC_POP 8'hde
`define FMU_MUL_REG 3'h1
`define FMU_RESP_OK 2'b00
`define FMU_RESP_ERR 2'b10
`endif

// ===== fmu_pkg.sv
package fmu_pkg;
	typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_MUL = 2'b10} state_t;
	typedef enum logic [1:0] {MODE_REAL = 2'b00, MODE_PROT = 2'b01,
		MODE_V86 = 2'b10} mode_t;
	typedef struct packed {
		logic [7:0] opc;
		logic [7:0] modrm;
		logic [63:0] mem;
		mode_t mode;
		logic [1:0] cpl;
		logic seg_lim;
		logic ss_lim;
		logic null_sel;
		logic unaligned;
		logic page_flt;
		logic [15:0] pf_code;
	} req_t;
	typedef struct packed {
		logic is, ia, de, ue, oe, pe, nm, gp, ss, pf, ac;
	} exc_t;
	typedef struct packed {
		exc_t exc;
		logic c1;
		logic [15:0] fault_code;
	} resp_t;
	typedef struct packed {
		logic sign;
		logic [14:0] exp;
		logic [63:0] man;
		logic zero, inf, nan, snan, den, unsup;
	} opnd_t;
endpackage

// ===== fpu_multiply_unit.sv
// Operation
// - single-real memory form: top times operand, product into top
// - double-real memory form: top times operand, product into top
// - register form: top times register i, product into top
// - reversed form: register i times top into register i
// - popping form: register i times top into register i, then pop
// - operand-less pop form: top times second register, always pop
// - integer memory operands converted to extended real first
// - destination always a data register; sources register or memory
// - pop marks top empty and increments top by one
// - product sign is xor of operand signs, zero and infinity too
// - integer zero counts as positive zero
// - invalid on signalling nan, unsupported format, zero times infinity
// - stack underflow raises stack fault and clears flag one
// - on inexact, flag one records round-up direction; the code leaves flag one clear on overflow and underflow
// - denormal, underflow, overflow, inexact flagged separately
// - protected mode: limit or null selector gives protection fault
// - stack segment limit fault in every mode
// - emulation or task-switched bit blocks multiply with fault
// - alignment fault at level 3 protected, always in v86
// - page fault passed with its code in protected and v86
// - rounding follows rounding control field; the code gives infinity on overflow and zero on underflow in every mode
//
// Decided for this implementation: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "fmu_defs.svh"
module fpu_multiply_unit
(
	input wire logic I_CLOCK,
	input wire logic I_SYS_RST,
	input wire logic I_REQ_VALID,
	input wire fmu_pkg::req_t I_REQ,
	output logic O_REQ_READY,
	output logic O_DONE,
	output fmu_pkg::resp_t O_RESP,
	input wire logic [7:0] I_AWADDR,
	input wire logic I_AWVALID,
	output logic O_AWREADY,
	input wire logic [31:0] I_WDATA,
	input wire logic [3:0] I_WSTRB,
	input wire logic I_WVALID,
	output logic O_WREADY,
	output logic [1:0] O_BRESP,
	output logic O_BVALID,
	input wire logic I_BREADY,
	input wire logic [7:0] I_ARADDR,
	input wire logic I_ARVALID,
	output logic O_ARREADY,
	output logic [31:0] O_RDATA,
	output logic [1:0] O_RRESP,
	output logic O_RVALID,
	input wire logic I_RREADY
);
	// =========================================================
	// operand unpacking
	function automatic fmu_pkg::opnd_t unp_ext(input logic [79:0] x);
		fmu_pkg::opnd_t o;
		o = '0;
		o.sign = x[79];
		o.exp = x[78:64];
		o.man = x[63:0];
		if (x[78:64] == `FMU_EXP_MAX)
		begin
			o.inf = x[63] & ~|x[62:0];
			o.nan = x[63] & |x[62:0];
			o.snan = o.nan & ~x[62];
			o.unsup = ~x[63];
		end
		else if (x[78:64] == 15'h0000)
		begin
			o.zero = ~|x[63:0];
			o.den = |x[63:0];
			o.exp = 15'h0001;
		end
		else
			o.unsup = ~x[63];
		return o;
	endfunction

	function automatic fmu_pkg::opnd_t unp_sgl(input logic [31:0] w);
		fmu_pkg::opnd_t o;
		o = '0;
		o.sign = w[31];
		o.man = {1'b1, w[22:0], 40'h0};
		o.exp = {7'h00, w[30:23]} + `FMU_SGL_ADJ;
		if (w[30:23] == 8'hff)
		begin
			o.inf = ~|w[22:0];
			o.nan = |w[22:0];
			o.snan = o.nan & ~w[22];
			o.exp = `FMU_EXP_MAX;
		end
		else if (w[30:23] == 8'h00)
		begin
			o.zero = ~|w[22:0];
			o.den = |w[22:0];
			o.man[63] = 1'b0;
			o.exp = `FMU_SGL_ADJ + 15'h0001;
		end
		return o;
	endfunction

	function automatic fmu_pkg::opnd_t unp_dbl(input logic [63:0] d);
		fmu_pkg::opnd_t o;
		o = '0;
		o.sign = d[63];
		o.man = {1'b1, d[51:0], 11'h000};
		o.exp = {4'h0, d[62:52]} + `FMU_DBL_ADJ;
		if (d[62:52] == 11'h7ff)
		begin
			o.inf = ~|d[51:0];
			o.nan = |d[51:0];
			o.snan = o.nan & ~d[51];
			o.exp = `FMU_EXP_MAX;
		end
		else if (d[62:52] == 11'h000)
		begin
			o.zero = ~|d[51:0];
			o.den = |d[51:0];
			o.man[63] = 1'b0;
			o.exp = `FMU_DBL_ADJ + 15'h0001;
		end
		return o;
	endfunction

	// integer to extended real, left unnormalised
	function automatic fmu_pkg::opnd_t unp_int(input logic [31:0] v);
		fmu_pkg::opnd_t o;
		logic [31:0] mag;
		o = '0;
		mag = v[31] ? (32'h0 - v) : v;
		o.zero = ~|v;
		o.sign = v[31] & |v;
		o.man = {mag, 32'h0};
		o.exp = `FMU_INT_EXP;
		return o;
	endfunction

	function automatic logic [7:0] lzc(input logic [127:0] p);
		logic [7:0] n;
		logic hit;
		n = 8'h00;
		hit = 1'b0;
		for (int k = 127; k >= 0; k--)
		begin
			if (p[k])
				hit = 1'b1;
			else if (!hit)
				n = n + 8'h01;
		end
		return n;
	endfunction

	// =========================================================
	// state
	logic [79:0] stk [8];
	logic [7:0] tag;
	logic [2:0] top;
	logic [31:0] ctrl;
	fmu_pkg::exc_t stat;
	logic c1;
	fmu_pkg::state_t state;
	fmu_pkg::req_t req;
	logic req_rdy, done;
	fmu_pkg::resp_t resp;
	logic [31:0] stg_lo, stg_mid;
	logic [15:0] stg_hi;
	logic [2:0] sel;
	logic aw_rdy, w_rdy, bvalid, ar_rdy, rvalid;
	logic [7:0] aw_addr;
	logic [31:0] w_data, rdata;
	logic [3:0] w_strb;
	logic [1:0] bresp, rresp;
	logic bw_fire, stat_clr, w_map, r_map;
	logic [31:0] wmask, rmux;

	// =========================================================
	// decode of the held request
	logic is_reg, known, pop, uflow, fault, exec, go;
	logic [2:0] src_i, dst_i;
	fmu_pkg::exc_t flt;
	assign is_reg = req.modrm[7:6] == 2'b11;
	assign src_i = top + req.modrm[2:0];
	assign known = req.modrm[5:3] == `FMU_MUL_REG &&
		(req.opc == `FMU_OPC_SGL || req.opc == `FMU_OPC_DBL ||
		req.opc == `FMU_OPC_POP || (req.opc == `FMU_OPC_I32 && !is_reg));
	// pop forms; the operand-less one is i = 1
	assign pop = is_reg && req.opc == `FMU_OPC_POP;
	// destination is always a stack register
	assign dst_i = (!is_reg || req.opc == `FMU_OPC_SGL) ? top : src_i;
	assign uflow = !tag[top] || (is_reg && !tag[src_i]);
	assign exec = state == fmu_pkg::ST_MUL;

	// access faults; only nm blocks the arithmetic when memory is not used
	always_comb
	begin
		flt = '0;
		flt.nm = ctrl[`FMU_EM_BIT] | ctrl[`FMU_TS_BIT];
		flt.gp = !is_reg && (req.seg_lim ||
			(req.mode == fmu_pkg::MODE_PROT && req.null_sel));
		flt.ss = !is_reg && req.ss_lim;
		flt.pf = !is_reg && req.page_flt &&
			req.mode != fmu_pkg::MODE_REAL;
		flt.ac = !is_reg && ctrl[`FMU_ACEN_BIT] && req.unaligned &&
			((req.mode == fmu_pkg::MODE_PROT && req.cpl == 2'h3) ||
			req.mode == fmu_pkg::MODE_V86);
	end
	assign fault = |flt;
	assign go = exec && known && !fault && !uflow;

	// =========================================================
	// multiply datapath
	fmu_pkg::opnd_t oa, ob, om;
	logic sgn, g, st, up;
	logic [127:0] prod, sh;
	logic [7:0] lz;
	logic signed [17:0] ex, ex_r;
	logic [64:0] m65;
	logic [63:0] man_r;
	logic [79:0] res;
	fmu_pkg::exc_t fx;
	logic c1v;

	// memory operand by opcode
	always_comb
	begin
		case (req.opc)
			`FMU_OPC_SGL: om = unp_sgl(req.mem[31:0]);
			`FMU_OPC_DBL: om = unp_dbl(req.mem);
			`FMU_OPC_I32: om = unp_int(req.mem[31:0]);
			default: om = unp_int({{16{req.mem[15]}}, req.mem[15:0]});
		endcase
	end

	// mantissa product, normalise, round
	always_comb
	begin
		oa = unp_ext(stk[top]);
		ob = is_reg ? unp_ext(stk[src_i]) : om;
		sgn = oa.sign ^ ob.sign;
		prod = {64'h0, oa.man} * {64'h0, ob.man};
		lz = lzc(prod);
		sh = prod << lz;
		ex = $signed({3'h0, oa.exp}) + $signed({3'h0, ob.exp}) -
			`FMU_BIAS + 18'sh00001 - $signed({10'h000, lz});
		g = sh[63];
		st = |sh[62:0];
		case (ctrl[1:0])
			2'b00: up = g & (st | sh[64]);
			2'b01: up = (g | st) & sgn;
			2'b10: up = (g | st) & ~sgn;
			default: up = 1'b0;
		endcase
		m65 = {1'b0, sh[127:64]} + {64'h0, up};
		man_r = m65[64] ? `FMU_INT_BIT : m65[63:0];
		ex_r = m65[64] ? ex + 18'sh00001 : ex;
	end

	// special classes and exception flags
	always_comb
	begin
		fx = '0;
		c1v = 1'b0;
		res = {sgn, ex_r[14:0], man_r};
		if (uflow)
			fx.is = 1'b1;
		else
		begin
			fx.de = oa.den | ob.den;
			if (oa.snan | ob.snan | oa.unsup | ob.unsup |
				(oa.zero & ob.inf) | (oa.inf & ob.zero))
			begin
				fx.ia = 1'b1;
				res = `FMU_QNAN_IND;
			end
			else if (oa.nan | ob.nan)
				res = oa.nan ? {oa.sign, `FMU_EXP_MAX, oa.man} :
					{ob.sign, `FMU_EXP_MAX, ob.man};
			else if (oa.inf | ob.inf)
				res = {sgn, `FMU_EXP_MAX, `FMU_INT_BIT};
			else if (oa.zero | ob.zero)
				res = {sgn, 79'h0};
			else if (ex_r >= `FMU_EMAX)
			begin
				fx.oe = 1'b1;
				fx.pe = 1'b1;
				res = {sgn, `FMU_EXP_MAX, `FMU_INT_BIT};
			end
			else if (ex_r < 18'sh00001)
			begin
				fx.ue = 1'b1;
				fx.pe = 1'b1;
				res = {sgn, 79'h0};
			end
			else
			begin
				fx.pe = g | st;
				c1v = up & (g | st);
			end
		end
	end

	// =========================================================
	// request sequencing
	always_ff @(posedge I_CLOCK)
	begin
		if (I_SYS_RST)
		begin
			state <= fmu_pkg::ST_IDLE;
			req_rdy <= 1'b1;
			req <= '0;
		end
		else
		begin
			case (state)
				fmu_pkg::ST_IDLE:
					if (I_REQ_VALID && req_rdy)
					begin
						req <= I_REQ;
						req_rdy <= 1'b0;
						state <= fmu_pkg::ST_MUL;
					end
				fmu_pkg::ST_MUL:
				begin
					req_rdy <= 1'b1;
					state <= fmu_pkg::ST_IDLE;
				end
				default:
				begin
					req_rdy <= 1'b1;
					state <= fmu_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// answer of each operation, one cycle after execution
	always_ff @(posedge I_CLOCK)
	begin
		if (I_SYS_RST)
		begin
			done <= 1'b0;
			resp <= '0;
		end
		else
		begin
			done <= exec;
			if (exec)
			begin
				resp.exc <= !known ? '0 : (flt.nm ? flt : (fault ? flt : fx));
				resp.c1 <= go & c1v;
				resp.fault_code <= flt.pf ? req.pf_code : 16'h0000;
			end
		end
	end

	// stack registers: execution first, software load when idle
	always_ff @(posedge I_CLOCK)
	begin
		if (I_SYS_RST)
		begin
			tag <= `FMU_TAG_RST;
			top <= `FMU_TOP_RST;
		end
		else if (go)
		begin
			stk[dst_i] <= res;
			tag[dst_i] <= 1'b1;
			if (pop)
			begin
				tag[top] <= 1'b0;
				top <= top + 3'h1;
			end
		end
		else if (!exec && bw_fire && aw_addr == `FMU_TAGW)
		begin
			tag <= (tag & ~wmask[7:0]) | (w_data[7:0] & wmask[7:0]);
			if (w_strb[1])
				top <= w_data[`FMU_TOP_LSB+:3];
		end
		else if (!exec && bw_fire && aw_addr == `FMU_SEL &&
			w_strb[0] && w_data[`FMU_COMMIT_BIT])
			stk[w_data[2:0]] <= {stg_hi, stg_mid, stg_lo};
	end

	// sticky status, a new event wins over a write-one clear
	always_ff @(posedge I_CLOCK)
	begin
		if (I_SYS_RST)
		begin
			stat <= '0;
			c1 <= 1'b0;
		end
		else
		begin
			stat <= (stat & ~(stat_clr ? wmask[10:0] & w_data[10:0] : 11'h0)) |
				(exec && known ? (fault ? flt : fx) : '0);
			if (go)
				c1 <= c1v;
			else if (exec && known && !fault)
				c1 <= 1'b0;
		end
	end

	// =========================================================
	// axi4-lite slave
	assign bw_fire = !aw_rdy && !w_rdy && !bvalid;
	assign wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}},
		{8{w_strb[0]}}};
	assign stat_clr = bw_fire && aw_addr == `FMU_STAT;
	assign w_map = aw_addr <= `FMU_DHI && aw_addr[1:0] == 2'b00;
	assign r_map = I_ARADDR <= `FMU_DHI && I_ARADDR[1:0] == 2'b00;

	// read mux
	always_comb
	begin
		case (I_ARADDR)
			`FMU_CTRL: rmux = ctrl;
			`FMU_STAT: rmux = {15'h0, c1, 5'h00, stat};
			`FMU_TAGW: rmux = {21'h0, top, tag};
			`FMU_SEL: rmux = {29'h0, sel};
			`FMU_DLO: rmux = stk[sel][31:0];
			`FMU_DMID: rmux = stk[sel][63:32];
			`FMU_DHI: rmux = {16'h0, stk[sel][79:64]};
			default: rmux = 32'h0;
		endcase
	end

	// write channels taken in either order, response after both
	always_ff @(posedge I_CLOCK)
	begin
		if (I_SYS_RST)
		begin
			aw_rdy <= 1'b1;
			w_rdy <= 1'b1;
			bvalid <= 1'b0;
			bresp <= `FMU_RESP_OK;
			aw_addr <= 8'h00;
			w_data <= 32'h0;
			w_strb <= 4'h0;
		end
		else
		begin
			if (aw_rdy && I_AWVALID)
			begin
				aw_rdy <= 1'b0;
				aw_addr <= I_AWADDR;
			end
			if (w_rdy && I_WVALID)
			begin
				w_rdy <= 1'b0;
				w_data <= I_WDATA;
				w_strb <= I_WSTRB;
			end
			if (bw_fire)
			begin
				bvalid <= 1'b1;
				bresp <= w_map ? `FMU_RESP_OK : `FMU_RESP_ERR;
			end
			if (bvalid && I_BREADY)
			begin
				bvalid <= 1'b0;
				aw_rdy <= 1'b1;
				w_rdy <= 1'b1;
			end
		end
	end

	// software registers
	always_ff @(posedge I_CLOCK)
	begin
		if (I_SYS_RST)
		begin
			ctrl <= `FMU_CTRL_RST;
			sel <= 3'h0;
			stg_lo <= 32'h0;
			stg_mid <= 32'h0;
			stg_hi <= 16'h0000;
		end
		else if (bw_fire)
		begin
			case (aw_addr)
				`FMU_CTRL: ctrl <= ((ctrl & ~wmask) | (w_data & wmask)) &
					`FMU_CTRL_MASK;
				`FMU_SEL: if (w_strb[0]) sel <= w_data[2:0];
				`FMU_DLO: stg_lo <= (stg_lo & ~wmask) | (w_data & wmask);
				`FMU_DMID: stg_mid <= (stg_mid & ~wmask) | (w_data & wmask);
				`FMU_DHI: stg_hi <= (stg_hi & ~wmask[15:0]) |
					(w_data[15:0] & wmask[15:0]);
				default: sel <= sel;
			endcase
		end
	end

	// read channel
	always_ff @(posedge I_CLOCK)
	begin
		if (I_SYS_RST)
		begin
			ar_rdy <= 1'b1;
			rvalid <= 1'b0;
			rdata <= 32'h0;
			rresp <= `FMU_RESP_OK;
		end
		else if (ar_rdy && I_ARVALID)
		begin
			ar_rdy <= 1'b0;
			rvalid <= 1'b1;
			rdata <= rmux;
			rresp <= r_map ? `FMU_RESP_OK : `FMU_RESP_ERR;
		end
		else if (rvalid && I_RREADY)
		begin
			rvalid <= 1'b0;
			ar_rdy <= 1'b1;
		end
	end

	// outputs
	assign O_REQ_READY = req_rdy;
	assign O_DONE = done;
	assign O_RESP = resp;
	assign O_AWREADY = aw_rdy;
	assign O_WREADY = w_rdy;
	assign O_BVALID = bvalid;
	assign O_BRESP = bresp;
	assign O_ARREADY = ar_rdy;
	assign O_RVALID = rvalid;
	assign O_RDATA = rdata;
	assign O_RRESP = rresp;

	// =========================================================
	// checks
	default clocking cb @(posedge I_CLOCK); endclocking
	default disable iff (I_SYS_RST);

	nm_blocks_a: assert property (exec && flt.nm |-> !go ##1
		O_DONE && O_RESP.exc.nm) else $error("no fault on em or ts");
	pop_top_a: assert property (go && pop |=>
		top == $past(top) + 3'h1 && !tag[$past(top)])
		else $error("pop did not advance top");
	mem_dest_a: assert property (go && !is_reg |=>
		stk[$past(top)] == $past(res) && top == $past(top))
		else $error("memory form wrote wrong register");
	rev_dest_a: assert property (go && is_reg &&
		req.opc == `FMU_OPC_DBL |=> stk[$past(src_i)] == $past(res))
		else $error("reversed form result misplaced");
	sign_xor_a: assert property (go && !fx.ia && !(oa.nan | ob.nan)
		|=> stk[$past(dst_i)][79] == $past(sgn))
		else $error("product sign wrong");
	uflow_c1_a: assert property (exec && known && !fault && uflow
		|=> !c1 && stat.is && $stable(tag)) else $error("underflow c1");
	ia_zinf_a: assert property (go && oa.zero && ob.inf
		|=> O_RESP.exc.ia) else $error("zero times inf not invalid");
	ac_v86_a: assert property (exec && !is_reg &&
		req.mode == fmu_pkg::MODE_V86 && ctrl[`FMU_ACEN_BIT] &&
		req.unaligned |-> !go ##1 O_RESP.exc.ac)
		else $error("v86 alignment fault missing");
	done_lat_a: assert property (I_REQ_VALID && O_REQ_READY |=>
		!O_REQ_READY ##1 O_DONE && O_REQ_READY)
		else $error("done not two cycles after request");
endmodule

// ===== fmu_issuer.sv
`timescale 1ns/1ps
// ========
// decoder side: offers one request, holds it until taken
module fmu_issuer
(
	input wire logic i_clock,
	input wire logic i_ready,
	output logic o_valid,
	output fmu_pkg::req_t o_req
);
	// idle bus at start
	initial
	begin
		o_valid = 1'b0;
		o_req = '0;
	end
	// wait g edges, offer, hold to the ready edge, then scramble the bus
	task automatic send(input fmu_pkg::req_t r, input int g);
		repeat (g) @(posedge i_clock);
		o_valid <= 1'b1;
		o_req <= r;
		do
			@(posedge i_clock);
		while (!i_ready);
		o_valid <= 1'b0;
		o_req <= ~r;
	endtask
endmodule

// ===== test_fpu_multiply_unit.sv
`timescale 1ns/1ps
`include "fmu_defs.svh"
// ========
// multiply unit bench
module test_fpu_multiply_unit;
	localparam logic [78:0] two = 79'h4000_8000_0000_0000_0000;
	localparam logic [78:0] three = 79'h4000_c000_0000_0000_0000;
	localparam logic [78:0] six = 79'h4001_c000_0000_0000_0000;
	localparam logic [79:0] onep = 80'h3fff_8000_0000_0000_0001;
	localparam logic [79:0] inf = 80'h7fff_8000_0000_0000_0000;
	localparam logic [7:0] mopc [4] = '{8'hd8, 8'hdc, 8'hda, 8'hde};
	localparam logic [79:0] bad [3] = '{80'h0,
		80'h7fff_a000_0000_0000_0000, 80'h4000_4000_0000_0000_0000};
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic rv, rdy, done, s, t;
	fmu_pkg::req_t rq, q;
	fmu_pkg::resp_t resp;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hf;
	logic [31:0] rdata;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, rc;
	logic [63:0] m;
	logic [31:0] rnd = 32'h0001_0ae4;
	int error_cnt = 0;
	int comparisons = 0;
	int cyc = 0;
	fmu_pkg::resp_t exp_q[$];
	logic [1:0] exp_b[$];
	logic [33:0] exp_r[$];

	fpu_multiply_unit u_dut
	(
		.I_CLOCK(clock), .I_SYS_RST(rst), .I_REQ_VALID(rv), .I_REQ(rq),
		.O_REQ_READY(rdy), .O_DONE(done), .O_RESP(resp),
		.I_AWADDR(awaddr), .I_AWVALID(awvalid), .O_AWREADY(awready),
		.I_WDATA(wdata), .I_WSTRB(wstrb), .I_WVALID(wvalid),
		.O_WREADY(wready), .O_BRESP(bresp), .O_BVALID(bvalid),
		.I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid),
		.O_ARREADY(arready), .O_RDATA(rdata), .O_RRESP(rresp),
		.O_RVALID(rvalid), .I_RREADY(rready)
	);
	fmu_issuer u_issuer
	(
		.i_clock(clock), .i_ready(rdy), .o_valid(rv), .o_req(rq)
	);

	// clock
	always #2 clock = ~clock;

	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction

	task automatic fail(input string msg);
		error_cnt++;
		$display("CHECK FAILED %0t %s", $time, msg);
	endtask

	task automatic complete_run;
		if (error_cnt == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// ========
	// register bus master
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] e);
		@(posedge clock);
		exp_b.push_back(e);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge clock);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end
		while (!bvalid);
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [33:0] e);
		@(posedge clock);
		exp_r.push_back(e);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge clock);
			if (arready)
				arvalid <= 1'b0;
		end
		while (!rvalid);
		rready <= 1'b0;
	endtask

	// ========
	// stack access and operations
	task automatic put(input logic [2:0] i, input logic [79:0] v);
		wr(`FMU_DLO, v[31:0], 2'b00);
		wr(`FMU_DMID, v[63:32], 2'b00);
		wr(`FMU_DHI, {16'h0, v[79:64]}, 2'b00);
		wr(`FMU_SEL, {28'h0, 1'b1, i}, 2'b00);
	endtask

	task automatic peek(input logic [2:0] i, input logic [79:0] v);
		wr(`FMU_SEL, {29'h0, i}, 2'b00);
		rd(`FMU_DLO, {2'b00, v[31:0]});
		rd(`FMU_DMID, {2'b00, v[63:32]});
		rd(`FMU_DHI, {18'h0, v[79:64]});
	endtask

	// top 0, a in slot 0, b in slot j
	task automatic stk(input logic [79:0] a, b, input logic [2:0] j,
		input logic [7:0] tg);
		put(3'h0, a);
		put(j, b);
		wr(`FMU_TAGW, {24'h0, tg}, 2'b00);
	endtask

	task automatic op(input logic [7:0] c, md, input logic [63:0] mv,
		input fmu_pkg::resp_t e, input int g);
		q.opc = c;
		q.modrm = md;
		q.mem = mv;
		exp_q.push_back(e);
		u_issuer.send(q, g);
	endtask

	// memory form with mode, level and fault inputs
	task automatic flt(input logic [4:0] c, input logic [1:0] md, cp,
		input logic [4:0] f, input logic [10:0] e);
		wr(`FMU_CTRL, {27'h0, c}, 2'b00);
		q.mode = fmu_pkg::mode_t'(md);
		q.cpl = cp;
		{q.seg_lim, q.ss_lim, q.null_sel, q.unaligned, q.page_flt} = f;
		op(8'hd8, 8'h08, 64'h4040_0000, {e, 1'b0, f[0] ? 16'h1234 : 16'h0}, 1);
	endtask

	// compare each answer with the oldest note
	always @(posedge clock)
	begin
		if (!rst && done !== 1'b0)
		begin
			comparisons++;
			if (exp_q.size() == 0 || resp !== exp_q.pop_front())
				fail("op response");
		end
		if (bvalid && bready)
		begin
			comparisons++;
			if (exp_b.size() == 0 || bresp !== exp_b.pop_front())
				fail("write response");
		end
		if (rvalid && rready)
		begin
			comparisons++;
			if (exp_r.size() == 0 || {rresp, rdata} !== exp_r.pop_front())
				fail("read data");
		end
	end

	// hang guard
	always @(posedge clock)
	begin
		cyc++;
		if (cyc == 8000)
		begin
			error_cnt++;
			complete_run();
		end
	end

	// ========
	// main sequence
	initial
	begin
		q = '0;
		q.pf_code = 16'h1234;
		repeat (8) @(posedge clock);
		rst <= 1'b0;
		rd(`FMU_CTRL, 34'h0);
		rd(`FMU_TAGW, 34'h0);
		wr(`FMU_CTRL, 32'hffff_ffff, 2'b00);
		rd(`FMU_CTRL, 34'h1f);
		wr(`FMU_CTRL, 32'h0, 2'b00);
		wr(8'h40, 32'h1, 2'b10);
		rd(8'h40, {2'b10, 32'h0});
		for (int k = 0; k < 4; k++)
		begin
			rnd = lfsr(rnd);
			s = rnd[3];
			t = rnd[9];
			m = k == 0 ? {32'h0, s, 31'h4040_0000} :
				k == 1 ? {s, 63'h4008_0000_0000_0000} :
				s ? 64'hffff_ffff_ffff_fffd : 64'h3;
			stk({t, two}, {1'b0, three}, 3'h1, 8'h03);
			op(mopc[k], 8'h08, m, 28'h0, 1 + rnd[1:0]);
			peek(3'h0, {t ^ s, six});
		end
		stk({1'b1, two}, {1'b0, three}, 3'h1, 8'h03);
		op(8'hda, 8'h08, 64'h0, 28'h0, 2);
		peek(3'h0, 80'h8000_0000_0000_0000_0000);
		stk({1'b0, two}, {1'b1, three}, 3'h2, 8'h05);
		op(8'hd8, 8'hca, 64'h0, 28'h0, 3);
		peek(3'h0, {1'b1, six});
		// reversed form then register form back to back
		stk({1'b0, two}, {1'b0, three}, 3'h1, 8'h03);
		op(8'hdc, 8'hc9, 64'h0, 28'h0, 1);
		op(8'hd8, 8'hc9, 64'h0, 28'h0, 1);
		peek(3'h1, {1'b0, six});
		peek(3'h0, 80'h4002_c000_0000_0000_0000);
		stk({1'b0, two}, {1'b0, three}, 3'h2, 8'h05);
		op(8'hde, 8'hca, 64'h0, 28'h0, 2);
		peek(3'h2, {1'b0, six});
		rd(`FMU_TAGW, 34'h104);
		stk({1'b0, two}, {1'b1, three}, 3'h1, 8'h03);
		op(8'hde, 8'hc9, 64'h0, 28'h0, 4);
		peek(3'h1, {1'b1, six});
		rd(`FMU_TAGW, 34'h102);
		wstrb <= 4'h2;
		wr(`FMU_TAGW, 32'h0000_05ff, 2'b00);
		wstrb <= 4'hf;
		rd(`FMU_TAGW, 34'h502);
		for (int k = 0; k < 3; k++)
		begin
			stk(bad[k], k == 0 ? inf : {1'b0, two}, 3'h1, 8'h03);
			op(8'hd8, 8'hc9, 64'h0, {11'h200, 17'h0}, 1);
			peek(3'h0, `FMU_QNAN_IND);
		end
		stk(80'h7fff_c000_0000_0000_1234, {1'b0, two}, 3'h1, 8'h03);
		op(8'hd8, 8'hc9, 64'h0, 28'h0, 1);
		peek(3'h0, 80'h7fff_c000_0000_0000_1234);
		// rounding modes, round-up last so flag one is left set
		for (int k = 0; k < 4; k++)
		begin
			rc = 2'(k ^ (k >> 1));
			wr(`FMU_CTRL, {30'h0, rc}, 2'b00);
			stk(onep, onep, 3'h1, 8'h03);
			op(8'hd8, 8'hc9, 64'h0, {11'h020, rc == 2'h2, 16'h0}, 2);
			peek(3'h0, {onep[79:2], 1'b1, rc == 2'h2});
		end
		wr(`FMU_CTRL, 32'h0, 2'b00);
		wr(`FMU_STAT, 32'h7ff, 2'b00);
		stk({1'b0, two}, {1'b0, three}, 3'h1, 8'h01);
		op(8'hd8, 8'hc9, 64'h0, {11'h400, 17'h0}, 1);
		rd(`FMU_STAT, 34'h400);
		peek(3'h0, {1'b0, two});
		stk(80'h7ffe_ffff_ffff_ffff_ffff, {1'b0, two}, 3'h1, 8'h03);
		op(8'hd8, 8'hc9, 64'h0, {11'h060, 17'h0}, 1);
		peek(3'h0, inf);
		// denormal source, then a product too small
		stk(80'h0000_4000_0000_0000_0000, {1'b0, two}, 3'h1, 8'h03);
		op(8'hd8, 8'hc9, 64'h0, {11'h100, 17'h0}, 1);
		peek(3'h0, 80'h0001_8000_0000_0000_0000);
		stk(80'h0001_8000_0000_0000_0000, 80'h0001_8000_0000_0000_0000,
			3'h1, 8'h03);
		op(8'hd8, 8'hc9, 64'h0, {11'h0a0, 17'h0}, 1);
		peek(3'h0, 80'h0);
		stk({1'b0, two}, {1'b0, three}, 3'h1, 8'h03);
		flt(5'h04, 2'h0, 2'h0, 5'h00, 11'h010);
		flt(5'h08, 2'h1, 2'h0, 5'h00, 11'h010);
		flt(5'h00, 2'h1, 2'h0, 5'h10, 11'h008);
		flt(5'h00, 2'h1, 2'h0, 5'h04, 11'h008);
		flt(5'h00, 2'h0, 2'h0, 5'h08, 11'h004);
		flt(5'h00, 2'h2, 2'h0, 5'h08, 11'h004);
		flt(5'h00, 2'h1, 2'h0, 5'h01, 11'h002);
		flt(5'h00, 2'h2, 2'h0, 5'h01, 11'h002);
		flt(5'h10, 2'h1, 2'h3, 5'h02, 11'h001);
		flt(5'h10, 2'h2, 2'h0, 5'h02, 11'h001);
		peek(3'h0, {1'b0, two});
		flt(5'h10, 2'h1, 2'h0, 5'h02, 11'h000);
		peek(3'h0, {1'b0, six});
		// let the monitor take the last answer first
		repeat (2) @(posedge clock);
		if (exp_q.size() + exp_b.size() + exp_r.size() != 0)
			fail("missing answer");
		complete_run();
	end
endmodule
